// ===== mcch_defines.svh
// Function
// RQ1: Filter depth only 1,16,64,256,512,1024; default 64
// RQ2: Filter depth reads back stored value
// RQ3: Kill enable stored, default off, readable
// RQ4: Fine trim stored, default on, readable
// RQ5: Clear-all wipes module event status
// RQ6: Reset word clears status bits set
// RQ7: Event mask loads from written word
// RQ8: Event mask reads back current contents
// RQ9: Channel event mask loads and reads back
// RQ10: CAN address 0..63, configuration mode only
// RQ11: CAN address reads back stored value
// RQ12: CAN rate 125000/250000, configuration mode only
// RQ13: CAN rate reads back current value
// RQ14: Serial baud query returns rate in use
// RQ15: Switch to 115200 on request, keep using
// RQ16: Host sends switch and query together
// RQ17: Revert to 9600 after 10 s idle
// RQ18: Echo enabled echoes every received character
// RQ19: Echo disabled sends nothing back
// RQ20: Echo query reports 1 or 0
// RQ21: Host disables echo only with care
// RQ22: Invalid or out-of-mode writes leave value
`ifndef MCCH_DEFINES_SVH
`define MCCH_DEFINES_SVH
`define MCCH_A_FILTER     12'h000
`define MCCH_A_KILL       12'h004
`define MCCH_A_TRIM       12'h008
`define MCCH_A_EVSTAT     12'h00c
`define MCCH_A_EVCLRALL   12'h010
`define MCCH_A_EVMASK     12'h014
`define MCCH_A_CHMASK     12'h018
`define MCCH_A_CANADDR    12'h01c
`define MCCH_A_CANRATE    12'h020
`define MCCH_A_BAUD       12'h024
`define MCCH_A_ECHO       12'h028
`define MCCH_A_CFGMODE    12'h02c
`define MCCH_RST_FILTER   32'd64
`define MCCH_RST_KILL     1'b0
`define MCCH_RST_TRIM     1'b1
`define MCCH_RST_ECHO     1'b1
`define MCCH_RST_CANRATE  32'd125000
`define MCCH_RATE_LO      32'd125000
`define MCCH_RATE_HI      32'd250000
`define MCCH_BAUD_SLOW    32'd9600
`define MCCH_BAUD_FAST    32'd115200
`define MCCH_CANADDR_MAX  32'd63
`define MCCH_CLK_HZ       20000000
`define MCCH_IDLE_S       10
`define MCCH_IDLE_CYC     (`MCCH_IDLE_S * `MCCH_CLK_HZ)
`endif

// ===== mcch_pkg.sv
package mcch_pkg;
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } mcch_char_t;
   typedef enum logic {MCCH_SLOW, MCCH_FAST} mcch_baud_t;
endpackage

// ===== mcch_top.sv
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/10ps
`include "mcch_defines.svh"
module mcch_top #(
   parameter int unsigned IDLE_CYC = `MCCH_IDLE_CYC
) (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic [15:0]         event_set,
   input  wire mcch_pkg::mcch_char_t rx_char,
   output mcch_pkg::mcch_char_t     tx_echo,
   output logic                     fast_baud,
   output logic      [10:0]         filter_depth_setting,
   output logic                     kill_enable,
   output logic                     fine_trim_setting,
   output logic      [5:0]          can_node_addr,
   output logic                     can_line_rate
);
   logic [10:0] filter_q;
   logic        kill_q;
   logic        trim_q;
   logic [15:0] evstat_q;
   logic [15:0] evmask_q;
   logic [15:0] channel_event_enable_word_q;
   logic [5:0]  canaddr_q;
   logic        canrate_q;
   logic        echo_q;
   logic        cfgmode_q;
   mcch_pkg::mcch_baud_t baud_q;
   logic [31:0] idle_q;
   logic [31:0] prdata_q;
   logic        pready_q;
   logic        pslverr_q;
   mcch_pkg::mcch_char_t echo_q_out;
   logic        wr;
   logic        rd;
   logic        mapped;
   logic [31:0] rdata_d;

   function automatic logic filter_ok(input logic [31:0] v);
      filter_ok = (v == 32'd1) || (v == 32'd16) || (v == 32'd64) ||
                  (v == 32'd256) || (v == 32'd512) || (v == 32'd1024);
   endfunction

   // Access phase; one wait state given by pready_q
   assign wr = psel && penable && pwrite && pready_q;
   assign rd = psel && penable && !pwrite && !pready_q;

   always_comb
   begin
      mapped  = 1'b1;
      rdata_d = 32'h0;
      case (paddr)
         `MCCH_A_FILTER:   rdata_d = {21'h0, filter_q};                                 // [RQ2]
         `MCCH_A_KILL:     rdata_d = {31'h0, kill_q};                                   // [RQ3]
         `MCCH_A_TRIM:     rdata_d = {31'h0, trim_q};                                   // [RQ4]
         `MCCH_A_EVSTAT:   rdata_d = {16'h0, evstat_q};
         `MCCH_A_EVCLRALL: rdata_d = 32'h0;
         `MCCH_A_EVMASK:   rdata_d = {16'h0, evmask_q};                                 // [RQ8]
         `MCCH_A_CHMASK:   rdata_d = {16'h0, channel_event_enable_word_q};              // [RQ9]
         `MCCH_A_CANADDR:  rdata_d = {26'h0, canaddr_q};                                // [RQ11]
         `MCCH_A_CANRATE:  rdata_d = canrate_q ? `MCCH_RATE_HI : `MCCH_RATE_LO;         // [RQ13]
         `MCCH_A_BAUD:     rdata_d = (baud_q == mcch_pkg::MCCH_FAST) ? `MCCH_BAUD_FAST
                                                                      : `MCCH_BAUD_SLOW; // [RQ14]
         `MCCH_A_ECHO:     rdata_d = {31'h0, echo_q};                                   // [RQ20]
         `MCCH_A_CFGMODE:  rdata_d = {31'h0, cfgmode_q};
         default:          mapped = 1'b0;
      endcase
   end

   // Bus answer: pready one cycle after access phase begins
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0;
      end
      else
      begin
         pready_q  <= psel && penable && !pready_q;
         pslverr_q <= psel && penable && !pready_q && !mapped;
         if (rd)
            prdata_q <= rdata_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         filter_q <= 11'(`MCCH_RST_FILTER);
         kill_q   <= `MCCH_RST_KILL;
         trim_q   <= `MCCH_RST_TRIM;
         echo_q   <= `MCCH_RST_ECHO;
         cfgmode_q <= 1'b0;
         evmask_q <= 16'h0;
         channel_event_enable_word_q <= 16'h0;
      end
      else if (wr)
      begin
         case (paddr)
            `MCCH_A_FILTER:
               if (filter_ok(pwdata))                     // [RQ1] [RQ22]
                  filter_q <= pwdata[10:0];
            `MCCH_A_KILL:
               if (pwdata[31:1] == 31'h0)                 // [RQ22]
                  kill_q <= pwdata[0];                    // [RQ3]
            `MCCH_A_TRIM:
               if (pwdata[31:1] == 31'h0)                 // [RQ22]
                  trim_q <= pwdata[0];                    // [RQ4]
            `MCCH_A_ECHO:
               if (pwdata[31:1] == 31'h0)                 // [RQ22]
                  echo_q <= pwdata[0];
            `MCCH_A_CFGMODE: cfgmode_q <= pwdata[0];
            `MCCH_A_EVMASK:  evmask_q <= pwdata[15:0];    // [RQ7]
            `MCCH_A_CHMASK:  channel_event_enable_word_q <= pwdata[15:0]; // [RQ9]
            default: ;
         endcase
      end
   end

   // CAN settings only change in configuration mode
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         canaddr_q <= 6'h0;
         canrate_q <= 1'b0;
      end
      else if (wr && cfgmode_q)                           // [RQ10] [RQ12] [RQ22]
      begin
         if (paddr == `MCCH_A_CANADDR && pwdata <= `MCCH_CANADDR_MAX)
            canaddr_q <= pwdata[5:0];                     // [RQ10]
         if (paddr == `MCCH_A_CANRATE && (pwdata == `MCCH_RATE_LO || pwdata == `MCCH_RATE_HI))
            canrate_q <= (pwdata == `MCCH_RATE_HI);       // [RQ12]
      end
   end

   // Event status: set wins over clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         evstat_q <= 16'h0;
      else if (wr && paddr == `MCCH_A_EVCLRALL)
         evstat_q <= event_set;                           // [RQ5]
      else if (wr && paddr == `MCCH_A_EVSTAT)
         evstat_q <= (evstat_q & ~pwdata[15:0]) | event_set; // [RQ6]
      else
         evstat_q <= evstat_q | event_set;
   end

   // Baud switch and idle fallback
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         baud_q <= mcch_pkg::MCCH_SLOW;
         idle_q <= 32'h0;
      end
      else
      begin
         // A character or a baud command restarts the idle timer
         if (rx_char.valid || (wr && paddr == `MCCH_A_BAUD))
            idle_q <= 32'h0;
         else if (idle_q < IDLE_CYC)
            idle_q <= idle_q + 32'h1;
         if (wr && paddr == `MCCH_A_BAUD && pwdata == `MCCH_BAUD_FAST)
            baud_q <= mcch_pkg::MCCH_FAST;                // [RQ15]
         else if (wr && paddr == `MCCH_A_BAUD && pwdata == `MCCH_BAUD_SLOW)
            baud_q <= mcch_pkg::MCCH_SLOW;
         else if (!rx_char.valid && idle_q == IDLE_CYC - 1)
            baud_q <= mcch_pkg::MCCH_SLOW;                // [RQ17]
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         echo_q_out <= '0;
      else
      begin
         echo_q_out.valid <= rx_char.valid && echo_q;     // [RQ18] [RQ19]
         echo_q_out.data  <= rx_char.data;
      end
   end

   assign prdata               = prdata_q;
   assign pready               = pready_q;
   assign pslverr              = pslverr_q;
   assign tx_echo              = echo_q_out;
   assign fast_baud            = baud_q;
   assign filter_depth_setting = filter_q;
   assign kill_enable          = kill_q;
   assign fine_trim_setting    = trim_q;
   assign can_node_addr        = canaddr_q;
   assign can_line_rate        = canrate_q;

   property p_echo_on;
      @(posedge pclk) disable iff (!presetn)
      (rx_char.valid && echo_q) |=> (tx_echo.valid && tx_echo.data == $past(rx_char.data));
   endproperty
   a_echo_on: assert property (p_echo_on) else $error("echo missing"); // [RQ18]

   property p_echo_off;
      @(posedge pclk) disable iff (!presetn)
      !echo_q |=> !tx_echo.valid;
   endproperty
   a_echo_off: assert property (p_echo_off) else $error("echo while disabled"); // [RQ19]

   property p_filter_legal;
      @(posedge pclk) disable iff (!presetn)
      filter_ok({21'h0, filter_depth_setting});
   endproperty
   a_filter_legal: assert property (p_filter_legal) else $error("illegal filter depth"); // [RQ1]

   property p_can_locked;
      @(posedge pclk) disable iff (!presetn)
      !cfgmode_q |=> $stable(can_node_addr) && $stable(can_line_rate);
   endproperty
   a_can_locked: assert property (p_can_locked) else $error("CAN changed outside config"); // [RQ10]

   property p_clrall;
      @(posedge pclk) disable iff (!presetn)
      (wr && paddr == `MCCH_A_EVCLRALL) |=> (evstat_q == $past(event_set));
   endproperty
   a_clrall: assert property (p_clrall) else $error("clear all failed"); // [RQ5]

   property p_clrbits;
      @(posedge pclk) disable iff (!presetn)
      (wr && paddr == `MCCH_A_EVSTAT) |=>
         evstat_q == (($past(evstat_q) & ~$past(pwdata[15:0])) | $past(event_set));
   endproperty
   a_clrbits: assert property (p_clrbits) else $error("bit clear wrong"); // [RQ6]

   property p_baud_fast;
      @(posedge pclk) disable iff (!presetn)
      (wr && paddr == `MCCH_A_BAUD && pwdata == `MCCH_BAUD_FAST) |=> fast_baud;
   endproperty
   a_baud_fast: assert property (p_baud_fast) else $error("no switch to fast"); // [RQ15]

   property p_idle_fallback;
      @(posedge pclk) disable iff (!presetn)
      (idle_q == IDLE_CYC - 1 && !rx_char.valid && !wr) |=> !fast_baud;
   endproperty
   a_idle_fallback: assert property (p_idle_fallback) else $error("no idle fallback"); // [RQ17]

   property p_mask_load;
      @(posedge pclk) disable iff (!presetn)
      (wr && paddr == `MCCH_A_EVMASK) |=> evmask_q == $past(pwdata[15:0]);
   endproperty
   a_mask_load: assert property (p_mask_load) else $error("mask not loaded"); // [RQ7]

   // Accepted write to one offset
   sequence s_wr(logic [11:0] a);
      wr && paddr == a;
   endsequence

   // First access cycle of a read to one offset
   sequence s_rd(logic [11:0] a);
      psel && penable && !pwrite && !pready_q && paddr == a;
   endsequence

   property p_chmask_load;
      @(posedge pclk) disable iff (!presetn)
      s_wr(`MCCH_A_CHMASK) |=> channel_event_enable_word_q == $past(pwdata[15:0]);
   endproperty
   a_chmask_load: assert property (p_chmask_load) else $error("channel mask not loaded"); // [RQ9]

   property p_kill_load;
      @(posedge pclk) disable iff (!presetn)
      s_wr(`MCCH_A_KILL) ##0 (pwdata[31:1] == 31'h0) |=> kill_enable == $past(pwdata[0]);
   endproperty
   a_kill_load: assert property (p_kill_load) else $error("kill not loaded"); // [RQ3]

   property p_kill_keep;
      @(posedge pclk) disable iff (!presetn)
      s_wr(`MCCH_A_KILL) ##0 (pwdata[31:1] != 31'h0) |=> $stable(kill_enable);
   endproperty
   a_kill_keep: assert property (p_kill_keep) else $error("kill changed by bad value"); // [RQ22]

   property p_trim_load;
      @(posedge pclk) disable iff (!presetn)
      s_wr(`MCCH_A_TRIM) ##0 (pwdata[31:1] == 31'h0) |=> fine_trim_setting == $past(pwdata[0]);
   endproperty
   a_trim_load: assert property (p_trim_load) else $error("trim not loaded"); // [RQ4]

   property p_trim_keep;
      @(posedge pclk) disable iff (!presetn)
      s_wr(`MCCH_A_TRIM) ##0 (pwdata[31:1] != 31'h0) |=> $stable(fine_trim_setting);
   endproperty
   a_trim_keep: assert property (p_trim_keep) else $error("trim changed by bad value"); // [RQ22]

   property p_echo_load;
      @(posedge pclk) disable iff (!presetn)
      s_wr(`MCCH_A_ECHO) ##0 (pwdata[31:1] == 31'h0) |=> echo_q == $past(pwdata[0]);
   endproperty
   a_echo_load: assert property (p_echo_load) else $error("echo not loaded"); // [RQ20]

   property p_echo_keep;
      @(posedge pclk) disable iff (!presetn)
      s_wr(`MCCH_A_ECHO) ##0 (pwdata[31:1] != 31'h0) |=> $stable(echo_q);
   endproperty
   a_echo_keep: assert property (p_echo_keep) else $error("echo changed by bad value"); // [RQ22]

   property p_filter_load;
      @(posedge pclk) disable iff (!presetn)
      s_wr(`MCCH_A_FILTER) ##0 filter_ok(pwdata) |=> filter_depth_setting == $past(pwdata[10:0]);
   endproperty
   a_filter_load: assert property (p_filter_load) else $error("filter not loaded"); // [RQ1]

   property p_filter_keep;
      @(posedge pclk) disable iff (!presetn)
      s_wr(`MCCH_A_FILTER) ##0 !filter_ok(pwdata) |=> $stable(filter_depth_setting);
   endproperty
   a_filter_keep: assert property (p_filter_keep) else $error("filter changed by bad value"); // [RQ22]

   property p_canaddr_load;
      @(posedge pclk) disable iff (!presetn)
      s_wr(`MCCH_A_CANADDR) ##0 (cfgmode_q && pwdata <= `MCCH_CANADDR_MAX) |=>
         can_node_addr == $past(pwdata[5:0]);
   endproperty
   a_canaddr_load: assert property (p_canaddr_load) else $error("CAN address not loaded"); // [RQ10]

   property p_canaddr_keep;
      @(posedge pclk) disable iff (!presetn)
      s_wr(`MCCH_A_CANADDR) ##0 (pwdata > `MCCH_CANADDR_MAX) |=> $stable(can_node_addr);
   endproperty
   a_canaddr_keep: assert property (p_canaddr_keep) else $error("CAN address out of range taken"); // [RQ22]

   property p_canrate_load;
      @(posedge pclk) disable iff (!presetn)
      s_wr(`MCCH_A_CANRATE) ##0 (cfgmode_q && pwdata == `MCCH_RATE_HI) |=> can_line_rate;
   endproperty
   a_canrate_load: assert property (p_canrate_load) else $error("CAN rate not loaded"); // [RQ12]

   property p_rd_filter;
      @(posedge pclk) disable iff (!presetn)
      s_rd(`MCCH_A_FILTER) |=> pready && prdata == {21'h0, $past(filter_depth_setting)};
   endproperty
   a_rd_filter: assert property (p_rd_filter) else $error("filter read wrong"); // [RQ2]

   property p_rd_evmask;
      @(posedge pclk) disable iff (!presetn)
      s_rd(`MCCH_A_EVMASK) |=> pready && prdata == {16'h0, $past(evmask_q)};
   endproperty
   a_rd_evmask: assert property (p_rd_evmask) else $error("event mask read wrong"); // [RQ8]

   property p_rd_canaddr;
      @(posedge pclk) disable iff (!presetn)
      s_rd(`MCCH_A_CANADDR) |=> pready && prdata == {26'h0, $past(can_node_addr)};
   endproperty
   a_rd_canaddr: assert property (p_rd_canaddr) else $error("CAN address read wrong"); // [RQ11]

   property p_rd_canrate;
      @(posedge pclk) disable iff (!presetn)
      s_rd(`MCCH_A_CANRATE) |=> prdata == ($past(can_line_rate) ? `MCCH_RATE_HI : `MCCH_RATE_LO);
   endproperty
   a_rd_canrate: assert property (p_rd_canrate) else $error("CAN rate read wrong"); // [RQ13]

   property p_rd_baud;
      @(posedge pclk) disable iff (!presetn)
      s_rd(`MCCH_A_BAUD) |=> prdata == ($past(fast_baud) ? `MCCH_BAUD_FAST : `MCCH_BAUD_SLOW);
   endproperty
   a_rd_baud: assert property (p_rd_baud) else $error("baud read wrong"); // [RQ14]

   property p_rd_echo;
      @(posedge pclk) disable iff (!presetn)
      s_rd(`MCCH_A_ECHO) |=> pready && prdata == {31'h0, $past(echo_q)};
   endproperty
   a_rd_echo: assert property (p_rd_echo) else $error("echo read wrong"); // [RQ20]

   // Fast rate holds while the link is not idle long enough
   property p_baud_hold;
      @(posedge pclk) disable iff (!presetn)
      (fast_baud && idle_q < IDLE_CYC - 1 && !(wr && paddr == `MCCH_A_BAUD)) |=> fast_baud;
   endproperty
   a_baud_hold: assert property (p_baud_hold) else $error("fast rate dropped early"); // [RQ15]
endmodule

// ===== mcch_host_model.sv
`timescale 1ns/10ps
module mcch_host_model (
   input  wire logic            pclk,
   output mcch_pkg::mcch_char_t rx_char
);
   initial rx_char = '0;
   // One character per call, data line inverted when idle
   task automatic send(input logic [7:0] b);
      @(posedge pclk) rx_char <= {1'b1, b};
      @(posedge pclk) rx_char <= {1'b0, ~b};
   endtask
endmodule

// ===== module_config_command_handler_tb.sv
`timescale 1ns/10ps
`include "mcch_defines.svh"
module module_config_command_handler_tb;
   logic                 pclk;
   logic                 presetn;
   logic                 psel;
   logic                 penable;
   logic                 pwrite;
   logic [11:0]          paddr;
   logic [31:0]          pwdata;
   logic [31:0]          prdata;
   logic                 pready;
   logic                 pslverr;
   logic [15:0]          event_set;
   mcch_pkg::mcch_char_t rx_char;
   mcch_pkg::mcch_char_t tx_echo;
   logic                 fast_baud;
   logic [10:0]          filt;
   logic                 kill;
   logic                 trim;
   logic [5:0]           addr;
   logic                 rate;
   logic [31:0]          rdat;
   logic                 rerr;
   logic [31:0]          fl [6];
   int                   num_errors;
   int                   n_checks;

   mcch_top #(.IDLE_CYC(50)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .event_set(event_set), .rx_char(rx_char),
      .tx_echo(tx_echo), .fast_baud(fast_baud), .filter_depth_setting(filt),
      .kill_enable(kill), .fine_trim_setting(trim), .can_node_addr(addr), .can_line_rate(rate));
   mcch_host_model u_host (.pclk(pclk), .rx_char(rx_char));

   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   task summarize;
      if (num_errors == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         $display("Error %s expected %h seen %h", n, e, g);
         num_errors++;
      end
   endtask

   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do
      begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (pready !== 1'b1)
      begin
         num_errors++;
         summarize();
      end
      else
      begin
         rdat = prdata;
         rerr = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task rc(input string n, input logic [11:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(n, e, rdat);
   endtask

   initial
   begin
      num_errors = 0;
      n_checks = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      event_set = 16'h0;
      fl = '{32'h1, 32'h10, 32'h40, 32'h100, 32'h200, 32'h400};
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rc("filter", `MCCH_A_FILTER, 32'h40);
      rc("kill", `MCCH_A_KILL, 32'h0);
      rc("trim", `MCCH_A_TRIM, 32'h1);
      rc("echo", `MCCH_A_ECHO, 32'h1);
      rc("canrate", `MCCH_A_CANRATE, 32'h1e848);
      rc("baud", `MCCH_A_BAUD, 32'h2580);
      for (int k = 0; k < 6; k++)
      begin
         xfer(1'b1, `MCCH_A_FILTER, fl[k]);
         rc("filter", `MCCH_A_FILTER, fl[k]);
         chk("filter_port", fl[k], {21'h0, filt});
      end
      xfer(1'b1, `MCCH_A_FILTER, 32'h64);
      rc("filter", `MCCH_A_FILTER, 32'h400);
      xfer(1'b1, `MCCH_A_KILL, 32'h1);
      rc("kill", `MCCH_A_KILL, 32'h1);
      chk("kill_port", 32'h1, {31'h0, kill});
      xfer(1'b1, `MCCH_A_KILL, 32'h2);
      rc("kill", `MCCH_A_KILL, 32'h1);
      xfer(1'b1, `MCCH_A_TRIM, 32'h0);
      rc("trim", `MCCH_A_TRIM, 32'h0);
      chk("trim_port", 32'h0, {31'h0, trim});
      @(posedge pclk) event_set <= 16'h2005;
      @(posedge pclk) event_set <= 16'h0;
      rc("evstat", `MCCH_A_EVSTAT, 32'h2005);
      xfer(1'b1, `MCCH_A_EVSTAT, 32'h2000);
      rc("evstat", `MCCH_A_EVSTAT, 32'h5);
      xfer(1'b1, `MCCH_A_EVCLRALL, 32'h0);
      rc("evstat", `MCCH_A_EVSTAT, 32'h0);
      xfer(1'b1, `MCCH_A_EVMASK, 32'ha5c3);
      rc("evmask", `MCCH_A_EVMASK, 32'ha5c3);
      xfer(1'b1, `MCCH_A_CHMASK, 32'hff);
      rc("chmask", `MCCH_A_CHMASK, 32'hff);
      xfer(1'b1, `MCCH_A_CANADDR, 32'h17);
      rc("canaddr", `MCCH_A_CANADDR, 32'h0);
      xfer(1'b1, `MCCH_A_CANRATE, 32'h3d090);
      rc("canrate", `MCCH_A_CANRATE, 32'h1e848);
      xfer(1'b1, `MCCH_A_CFGMODE, 32'h1);
      xfer(1'b1, `MCCH_A_CANADDR, 32'h3f);
      rc("canaddr", `MCCH_A_CANADDR, 32'h3f);
      chk("addr_port", 32'h3f, {26'h0, addr});
      xfer(1'b1, `MCCH_A_CANADDR, 32'h40);
      rc("canaddr", `MCCH_A_CANADDR, 32'h3f);
      xfer(1'b1, `MCCH_A_CANRATE, 32'h3d090);
      rc("canrate", `MCCH_A_CANRATE, 32'h3d090);
      chk("rate_port", 32'h1, {31'h0, rate});
      xfer(1'b1, `MCCH_A_CANRATE, 32'h186a0);
      rc("canrate", `MCCH_A_CANRATE, 32'h3d090);
      xfer(1'b1, `MCCH_A_BAUD, 32'h1c200);
      rc("baud", `MCCH_A_BAUD, 32'h1c200);
      chk("fast", 32'h1, {31'h0, fast_baud});
      repeat (40) @(posedge pclk);
      u_host.send(8'h3a);
      #1;
      chk("echo_out", 32'h13a, {23'h0, tx_echo});
      repeat (40) @(posedge pclk);
      chk("fast", 32'h1, {31'h0, fast_baud});
      repeat (60) @(posedge pclk);
      rc("baud", `MCCH_A_BAUD, 32'h2580);
      chk("fast", 32'h0, {31'h0, fast_baud});
      xfer(1'b1, `MCCH_A_BAUD, 32'h1c200);
      repeat (60) @(posedge pclk);
      chk("fast_idle", 32'h0, {31'h0, fast_baud});
      xfer(1'b1, `MCCH_A_BAUD, 32'h1c200);
      xfer(1'b1, `MCCH_A_BAUD, 32'h2580);
      rc("baud", `MCCH_A_BAUD, 32'h2580);
      xfer(1'b1, `MCCH_A_ECHO, 32'h0);
      rc("echo", `MCCH_A_ECHO, 32'h0);
      u_host.send(8'h5a);
      #1;
      chk("echo_valid", 32'h0, {31'h0, tx_echo.valid});
      xfer(1'b1, `MCCH_A_ECHO, 32'h2);
      rc("echo", `MCCH_A_ECHO, 32'h0);
      rc("unmapped", 12'hffc, 32'h0);
      chk("slverr", 32'h1, {31'h0, rerr});
      summarize();
   end
endmodule
